// ==== hdl/fault_auto_restart_control.sv ====
// Fault auto-restart controller for a motor drive.
// What this block does
// R1 - Restart attempt limit 0..10, default 0, frozen while running.
// R2 - After an eligible trip, recheck the fault every 5 ms.
// R3 - When the polled fault is absent, start a restart with no command.
// R4 - Self-diagnose after a fault; restart only if diagnosis is clean.
// R5 - Each eligible fault while running below the limit advances the attempt counter.
// R6 - Ten fault-free running minutes restore the counter.
// R7 - Only the listed fourteen faults may be retried.
// R8 - Any other fault trips normally with no restart.
// R9 - Bus low voltage is eligible only with ride-through select 1 or 2.
// R10 - Contact outputs selecting code 1E show the auto-restart condition.
// R11 - Fault contact during retries: select 0 inactive, 1 active.
// R12 - Fault reset after an acknowledged trip clears the restart count.
// R13 - Power-up reinitialises the restart count.
// R14 - Resistor overheat raises its alarm and lets the motor coast.
// R15 - Resistor protection select 1 enables overheat protection, 0 omits.
// R16 - At the limit, stop retrying and hold the fault until reset.
module fault_auto_restart_control #(
    parameter longint unsigned CLEAN_RUN_CYCLES =
        restart_pkg::CLEAN_RUN_CYCLES,
    parameter int unsigned     POLL_CYCLES = restart_pkg::POLL_CYCLES
) (
    // Clock and reset.
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    // Configuration.
    input  wire logic [3:0]                    restart_attempt_limit,
    input  wire logic                          restart_fault_contact_select,
    input  wire logic                          resistor_protect_select,
    input  wire logic [1:0]                    power_loss_ride_through_select,
    input  wire logic [restart_pkg::N_CONTACT*8-1:0]
                                               contact_output_function_select,
    // Drive status and commands.
    input  wire logic                          run_cmd,
    input  wire logic [restart_pkg::N_FAULT-1:0] fault_in,
    input  wire logic                          diag_ok,
    input  wire logic                          fault_reset,
    // Outputs.
    output logic                               drive_enable,
    output logic                               coast_stop,
    output logic                               fault_contact,
    output logic                               auto_restart_active,
    output logic                               resistor_hot_alarm,
    output logic [restart_pkg::N_CONTACT-1:0]  contact_out,
    output logic [3:0]                         attempts_left
);
    restart_if cif ();
    restart_pkg::restart_state_t state_ff;
    logic [3:0] limit_ff;
    logic [3:0] used_ff;
    logic       poll_tick;
    logic       clean_done;
    logic       retrying;
    logic       limit_hit;

    assign cif.fault_vec  = fault_in;
    assign cif.ride_sel   = power_loss_ride_through_select;
    assign cif.protect_en = resistor_protect_select;

    fault_classifier u_cls (
        .cif (cif)
    );

    tick_counter #(.W(24)) u_poll (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .run      (state_ff == restart_pkg::ST_POLL), // R2
        .terminal (24'(POLL_CYCLES)),
        .done     (poll_tick)
    );

    tick_counter #(.W(40)) u_clean (
        .sys_clk  (sys_clk),
        .srst     (srst),
        // A faulted cycle clears the clean-run count, so the clean run starts again from zero.
        .run      ((state_ff == restart_pkg::ST_RUN) && (used_ff != 4'h0) &&
                   !cif.any_fault), // R6
        .terminal (40'(CLEAN_RUN_CYCLES)),
        .done     (clean_done)
    );

    assign limit_hit = (used_ff >= limit_ff); // R16
    assign retrying  = (state_ff == restart_pkg::ST_DIAG) ||
                       (state_ff == restart_pkg::ST_POLL) ||
                       (state_ff == restart_pkg::ST_RETRY);

    // The limit is latched only while stopped so a running drive keeps it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            limit_ff <= restart_pkg::LIMIT_RESET; // R1
        end else if (state_ff == restart_pkg::ST_IDLE) begin
            limit_ff <= (restart_attempt_limit > restart_pkg::LIMIT_MAX) ?
                        restart_pkg::LIMIT_MAX : restart_attempt_limit; // R1
        end
    end

    // Attempt bookkeeping.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            used_ff <= 4'h0; // R13
        end else if (state_ff == restart_pkg::ST_TRIP && fault_reset) begin
            used_ff <= 4'h0; // R12
        end else if (clean_done) begin
            used_ff <= 4'h0; // R6
        end else if (state_ff == restart_pkg::ST_RUN && cif.any_fault &&
                     cif.eligible && !limit_hit) begin
            used_ff <= used_ff + 4'h1; // R5
        end
    end

    // Sequencer.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= restart_pkg::ST_IDLE;
        end else begin
            unique case (state_ff)
                restart_pkg::ST_IDLE: begin
                    if (cif.any_fault) begin
                        state_ff <= restart_pkg::ST_TRIP;
                    end else if (run_cmd) begin
                        state_ff <= restart_pkg::ST_RUN;
                    end
                end
                restart_pkg::ST_RUN: begin
                    if (cif.hard_fault) begin
                        state_ff <= restart_pkg::ST_TRIP; // R8
                    end else if (cif.eligible) begin
                        state_ff <= limit_hit ? restart_pkg::ST_TRIP
                                              : restart_pkg::ST_DIAG; // R16
                    end else if (!run_cmd) begin
                        state_ff <= restart_pkg::ST_IDLE;
                    end
                end
                restart_pkg::ST_DIAG: begin
                    state_ff <= diag_ok ? restart_pkg::ST_POLL
                                        : restart_pkg::ST_TRIP; // R4
                end
                restart_pkg::ST_POLL: begin
                    if (cif.hard_fault) begin
                        state_ff <= restart_pkg::ST_TRIP;
                    end else if (poll_tick && !cif.any_fault) begin
                        state_ff <= restart_pkg::ST_RETRY; // R3
                    end
                end
                restart_pkg::ST_RETRY: begin
                    state_ff <= restart_pkg::ST_RUN; // R3
                end
                restart_pkg::ST_TRIP: begin
                    if (fault_reset && !cif.any_fault) begin
                        state_ff <= restart_pkg::ST_IDLE; // R12
                    end
                end
                default: begin
                    state_ff <= restart_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Registered outputs.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            drive_enable        <= 1'b0;
            coast_stop          <= 1'b0;
            fault_contact       <= 1'b0;
            auto_restart_active <= 1'b0;
            resistor_hot_alarm  <= 1'b0;
            attempts_left       <= 4'h0;
        end else begin
            drive_enable  <= (state_ff == restart_pkg::ST_RUN) &&
                             !cif.any_fault;
            coast_stop    <= (state_ff != restart_pkg::ST_RUN) ||
                             cif.any_fault; // R14
            fault_contact <= (state_ff == restart_pkg::ST_TRIP) ||
                             (retrying && restart_fault_contact_select); // R11
            auto_restart_active <= retrying;
            resistor_hot_alarm  <= fault_in[restart_pkg::F_BRAKE_HOT] &&
                                   resistor_protect_select; // R14
            attempts_left <= limit_hit ? 4'h0 : 4'(limit_ff - used_ff);
        end
    end

    generate
        for (genvar i = 0; i < restart_pkg::N_CONTACT; i++) begin : g_contact
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    contact_out[i] <= 1'b0;
                end else begin
                    contact_out[i] <= retrying &&
                        (contact_output_function_select[i*8 +: 8] ==
                         restart_pkg::FUNC_AUTO_RESTART); // R10
                end
            end
        end
    endgenerate

    property p_hard_trip;
        @(posedge sys_clk) disable iff (srst)
        (state_ff == restart_pkg::ST_RUN && cif.hard_fault)
            |=> state_ff == restart_pkg::ST_TRIP;
    endproperty
    a_hard_trip: assert property (p_hard_trip) // R8
        else $error("hard fault did not trip");

    property p_diag_bad;
        @(posedge sys_clk) disable iff (srst)
        (state_ff == restart_pkg::ST_DIAG && !diag_ok)
            |=> state_ff == restart_pkg::ST_TRIP;
    endproperty
    a_diag_bad: assert property (p_diag_bad) // R4
        else $error("failed diagnosis did not trip");

    property p_poll_wait;
        @(posedge sys_clk) disable iff (srst)
        $rose(state_ff == restart_pkg::ST_POLL)
            |-> !poll_tick;
    endproperty
    a_poll_wait: assert property (p_poll_wait) // R2
        else $error("poll tick came too early");

    property p_retry;
        @(posedge sys_clk) disable iff (srst)
        (state_ff == restart_pkg::ST_POLL && poll_tick && !cif.any_fault)
            |=> state_ff == restart_pkg::ST_RETRY ##1
                state_ff == restart_pkg::ST_RUN;
    endproperty
    a_retry: assert property (p_retry) // R3
        else $error("clear poll did not restart");

    property p_limit;
        @(posedge sys_clk) disable iff (srst)
        (state_ff == restart_pkg::ST_RUN && cif.eligible && limit_hit)
            |=> state_ff == restart_pkg::ST_TRIP;
    endproperty
    a_limit: assert property (p_limit) // R16
        else $error("retry beyond limit");

    property p_count;
        @(posedge sys_clk) disable iff (srst)
        (state_ff == restart_pkg::ST_RUN && cif.eligible && !limit_hit &&
         !clean_done) |=> used_ff == $past(used_ff) + 4'h1;
    endproperty
    a_count: assert property (p_count) // R5
        else $error("attempt counter did not advance");

    property p_reset_count;
        @(posedge sys_clk) disable iff (srst)
        (state_ff == restart_pkg::ST_TRIP && fault_reset) |=> used_ff == 4'h0;
    endproperty
    a_reset_count: assert property (p_reset_count) // R12
        else $error("fault reset kept the count");

    property p_contact;
        @(posedge sys_clk) disable iff (srst)
        (retrying && !restart_fault_contact_select) |=> !fault_contact;
    endproperty
    a_contact: assert property (p_contact) // R11
        else $error("fault contact active during retry");

    property p_limit_max;
        @(posedge sys_clk) disable iff (srst)
        limit_ff <= restart_pkg::LIMIT_MAX;
    endproperty
    a_limit_max: assert property (p_limit_max) // R1
        else $error("limit above ten");

    property p_poll_hold;
        @(posedge sys_clk) disable iff (srst)
        (state_ff == restart_pkg::ST_POLL && !poll_tick && !cif.hard_fault)
            |=> state_ff == restart_pkg::ST_POLL;
    endproperty
    a_poll_hold: assert property (p_poll_hold) // R2
        else $error("left polling between checks");

    property p_limit_frozen;
        @(posedge sys_clk) disable iff (srst)
        (state_ff != restart_pkg::ST_IDLE) |=> limit_ff == $past(limit_ff);
    endproperty
    a_limit_frozen: assert property (p_limit_frozen) // R1
        else $error("limit changed while not idle");

    property p_clean_restore;
        @(posedge sys_clk) disable iff (srst)
        clean_done |=> used_ff == 4'h0;
    endproperty
    a_clean_restore: assert property (p_clean_restore) // R6
        else $error("clean run did not restore the count");

    property p_alarm;
        @(posedge sys_clk) disable iff (srst)
        (fault_in[restart_pkg::F_BRAKE_HOT] && resistor_protect_select)
            |=> resistor_hot_alarm && coast_stop;
    endproperty
    a_alarm: assert property (p_alarm) // R14
        else $error("resistor overheat without alarm and coast");

    property p_contact_idle;
        @(posedge sys_clk) disable iff (srst)
        !retrying |=> contact_out == '0;
    endproperty
    a_contact_idle: assert property (p_contact_idle) // R10
        else $error("restart contact active outside retry");

    c_retry: cover property (@(posedge sys_clk)
        state_ff == restart_pkg::ST_RETRY);
    c_trip: cover property (@(posedge sys_clk)
        state_ff == restart_pkg::ST_TRIP && fault_reset);
    c_clean: cover property (@(posedge sys_clk) clean_done);
    c_limit: cover property (@(posedge sys_clk)
        state_ff == restart_pkg::ST_RUN && cif.eligible && limit_hit);
endmodule : fault_auto_restart_control

// ==== hdl/restart_pkg.sv ====
// Constants and types shared by the fault auto-restart controller.
package restart_pkg;
    localparam int unsigned CLK_MHZ            = 250;
    localparam int unsigned POLL_US            = 5000;
    localparam int unsigned POLL_CYCLES        = POLL_US * CLK_MHZ;
    localparam longint unsigned CLEAN_RUN_S    = 600;
    localparam longint unsigned CLEAN_RUN_CYCLES =
        CLEAN_RUN_S * 64'd1000000 * CLK_MHZ;
    localparam int unsigned LIMIT_W            = 4;
    localparam logic [3:0]  LIMIT_MAX          = 4'hA;
    localparam logic [3:0]  LIMIT_RESET        = 4'h0;
    localparam int unsigned N_FAULT            = 15;
    localparam int unsigned N_CONTACT          = 5;
    localparam logic [7:0]  FUNC_AUTO_RESTART  = 8'h1E;
    localparam logic [1:0]  RIDE_THROUGH_A     = 2'h1;
    localparam logic [1:0]  RIDE_THROUGH_B     = 2'h2;
    // Fault vector bit positions.
    localparam int unsigned F_OVERCURRENT      = 0;
    localparam int unsigned F_GROUND_LEAK      = 1;
    localparam int unsigned F_FUSE_BLOWN       = 2;
    localparam int unsigned F_BUS_HIGH         = 3;
    localparam int unsigned F_BUS_LOW          = 4;
    localparam int unsigned F_SUPPLY           = 5;
    localparam int unsigned F_PHASE_LOSS       = 6;
    localparam int unsigned F_BRAKE_HOT        = 7;
    localparam int unsigned F_BRAKE_SWITCH     = 8;
    localparam int unsigned F_MOTOR_OVERLOAD   = 9;
    localparam int unsigned F_DRIVE_OVERLOAD   = 10;
    localparam int unsigned F_MOTOR_OVERTEMP   = 11;
    localparam int unsigned F_TORQUE_A         = 12;
    localparam int unsigned F_TORQUE_B         = 13;
    localparam int unsigned F_OTHER            = 14;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_DIAG  = 3'b001,
        ST_POLL  = 3'b010,
        ST_RETRY = 3'b011,
        ST_TRIP  = 3'b100,
        ST_IDLE  = 3'b101
    } restart_state_t;
endpackage : restart_pkg

// ==== hdl/restart_if.sv ====
// Fault classification signals passed between the controller and classifier.
interface restart_if;
    logic [restart_pkg::N_FAULT-1:0] fault_vec;
    logic [1:0]                      ride_sel;
    logic                            protect_en;
    logic                            any_fault;
    logic                            eligible;
    logic                            hard_fault;
    modport ctrl (output fault_vec, output ride_sel, output protect_en,
                  input any_fault, input eligible, input hard_fault);
    modport cls  (input fault_vec, input ride_sel, input protect_en,
                  output any_fault, output eligible, output hard_fault);
endinterface : restart_if

// ==== hdl/fault_classifier.sv ====
// Sorts active faults into restart-eligible and protective-trip classes.
module fault_classifier (
    restart_if.cls cif
);
    logic [restart_pkg::N_FAULT-1:0] masked;
    logic [restart_pkg::N_FAULT-1:0] elig_mask;

    always_comb begin
        masked = cif.fault_vec;
        // Resistor overheat is only seen when its protection is enabled.
        masked[restart_pkg::F_BRAKE_HOT] =
            cif.fault_vec[restart_pkg::F_BRAKE_HOT] & cif.protect_en; // R15
        elig_mask = '1; // R7
        elig_mask[restart_pkg::F_OTHER] = 1'b0; // R8
        elig_mask[restart_pkg::F_BUS_LOW] =
            (cif.ride_sel == restart_pkg::RIDE_THROUGH_A) ||
            (cif.ride_sel == restart_pkg::RIDE_THROUGH_B); // R9
    end

    assign cif.any_fault  = |masked;
    assign cif.hard_fault = |(masked & ~elig_mask); // R8
    assign cif.eligible   = (|masked) && !cif.hard_fault; // R7
endmodule : fault_classifier

// ==== hdl/tick_counter.sv ====
// Counter, cleared whenever run is low, that pulses done on the terminal-th cycle of run.
module tick_counter #(
    parameter int unsigned W = 40
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic         run,
    input  wire logic [W-1:0] terminal,
    output logic              done
);
    logic [W-1:0] cnt_ff;

    always_ff @(posedge sys_clk) begin
        if (srst || !run || done) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign done = run && (cnt_ff == terminal - 1'b1);
endmodule : tick_counter

// ==== bench/drive_stage_model.sv ====
// Behavioural fault sensors and operator inputs facing the controller.
module drive_stage_model (
    // Clock.
    input  wire logic        sys_clk,
    // Requests from the bench.
    input  wire logic [14:0] want_fault,
    input  wire logic        want_diag_bad,
    input  wire logic        want_reset,
    // Lines seen by the controller.
    output logic      [14:0] fault_in,
    output logic             diag_ok,
    output logic             fault_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fault_in = 15'h0;
        diag_ok = 1'b1;
        fault_reset = 1'b0;
    end
    // Sensors move just after an edge and then hold as levels.
    always @(posedge sys_clk) begin
        fault_in    <= #1 want_fault;
        diag_ok     <= #1 !want_diag_bad;
        fault_reset <= #1 want_reset;
    end
endmodule : drive_stage_model

// ==== bench/tb_fault_auto_restart_control.sv ====
// Self-checking bench for the fault auto-restart controller.
module tb_fault_auto_restart_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int POLL  = 8;
    localparam int CLEAN = 50;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  limit = 4'h0;
    logic        contact_sel = 1'b0;
    logic        protect_sel = 1'b0;
    logic [1:0]  ride_sel = 2'h0;
    logic [39:0] func_sel = 40'h0;
    logic        run_cmd = 1'b0;
    logic [14:0] want_fault = 15'h0;
    logic        want_diag_bad = 1'b0;
    logic        want_reset = 1'b0;
    logic [14:0] fault_in;
    logic        diag_ok, fault_reset, drive_enable, coast_stop;
    logic        fault_contact, auto_restart_active, resistor_hot_alarm;
    logic [4:0]  contact_out;
    logic [3:0]  attempts_left;
    logic [4:0]  exp_c;
    int          lim, used, seed, bad_count, checked;

    always #2 sys_clk = ~sys_clk;

    drive_stage_model stage_u (
        .sys_clk(sys_clk), .want_fault(want_fault),
        .want_diag_bad(want_diag_bad), .want_reset(want_reset),
        .fault_in(fault_in), .diag_ok(diag_ok), .fault_reset(fault_reset));

    fault_auto_restart_control #(
        .CLEAN_RUN_CYCLES(CLEAN), .POLL_CYCLES(POLL)
    ) dut_u (
        .sys_clk(sys_clk), .srst(srst),
        .restart_attempt_limit(limit),
        .restart_fault_contact_select(contact_sel),
        .resistor_protect_select(protect_sel),
        .power_loss_ride_through_select(ride_sel),
        .contact_output_function_select(func_sel),
        .run_cmd(run_cmd), .fault_in(fault_in), .diag_ok(diag_ok),
        .fault_reset(fault_reset), .drive_enable(drive_enable),
        .coast_stop(coast_stop), .fault_contact(fault_contact),
        .auto_restart_active(auto_restart_active),
        .resistor_hot_alarm(resistor_hot_alarm),
        .contact_out(contact_out), .attempts_left(attempts_left));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wrap_up();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // Raise one fault while running; retried or tripped.
    task automatic hit(input int b, input bit retry);
        int n;
        n = 0;
        want_fault = 15'h1 << b;
        cyc(2 * POLL);
        chk(resistor_hot_alarm, b == 7 && protect_sel);
        chk(coast_stop, 1);
        if (retry) begin
            used++;
            chk(auto_restart_active, 1);
            chk(fault_contact, contact_sel);
            chk(contact_out, exp_c);
            chk(drive_enable, 0);
            chk(attempts_left, lim - used);
            want_fault = 15'h0;
            while (drive_enable !== 1'b1 && n < 3 * POLL + 20) begin
                cyc(1);
                n++;
            end
            chk(drive_enable, 1);
        end else begin
            chk(fault_contact, 1);
            chk(auto_restart_active, 0);
            chk(contact_out, 0);
        end
    endtask : hit

    task automatic clear_trip();
        want_fault = 15'h0;
        want_reset = 1'b1;
        cyc(3);
        want_reset = 1'b0;
        used = 0;
        cyc(4);
        chk(attempts_left, lim);
    endtask : clear_trip

    task automatic set_limit(input logic [3:0] l);
        run_cmd = 1'b0;
        cyc(3);
        limit = l;
        contact_sel = $random(seed) & 1;
        lim = (l > 10) ? 10 : l;
        cyc(3);
        run_cmd = 1'b1;
        cyc(4);
        chk(attempts_left, lim);
    endtask : set_limit

    initial begin
        #100us;
        bad_count++;
        wrap_up();
    end

    initial begin
        seed = 70363;
        lim = 0;
        used = 0;
        for (int i = 0; i < 5; i++) begin
            func_sel[8*i +: 8] = ($random(seed) & 1) ? 8'h1E
                : 8'h20 + ($random(seed) & 8'h3F);
            exp_c[i] = func_sel[8*i +: 8] == 8'h1E;
        end
        cyc(4);
        srst = 1'b0;
        cyc(2);
        chk(attempts_left, 0);
        chk(fault_contact, 0);
        chk(coast_stop, 1);
        $display("test reset done");
        run_cmd = 1'b1;
        cyc(4);
        hit(0, 0);
        clear_trip();
        $display("test zero limit done");
        protect_sel = 1'b1;
        set_limit(4'hC);
        for (int b = 0; b < 14; b++) begin
            ride_sel = 2'h1 + ($random(seed) & 1);
            contact_sel = b[0];
            hit(b, 1);
            cyc(CLEAN + 10);
            used = 0;
            chk(attempts_left, lim);
        end
        $display("test eligible set done");
        protect_sel = 1'b0;
        want_fault = 15'h0080;
        cyc(2 * POLL);
        chk(resistor_hot_alarm, 0);
        chk(drive_enable, 1);
        want_fault = 15'h0;
        cyc(2);
        ride_sel = ($random(seed) & 1) ? 2'h3 : 2'h0;
        hit(4, 0);
        clear_trip();
        hit(14, 0);
        clear_trip();
        want_diag_bad = 1'b1;
        hit(1, 0);
        want_diag_bad = 1'b0;
        clear_trip();
        $display("test trip classes done");
        set_limit(4'h2);
        hit(2, 1);
        limit = 4'h7;
        cyc(3);
        chk(attempts_left, lim - used);
        limit = 4'h2;
        hit(3, 1);
        hit(5, 0);
        chk(attempts_left, 0);
        clear_trip();
        $display("test exhaust done");
        hit(6, 1);
        run_cmd = 1'b0;
        limit = 4'h0;
        srst = 1'b1;
        cyc(4);
        srst = 1'b0;
        cyc(3);
        chk(attempts_left, 0);
        used = 0;
        set_limit(4'h3);
        $display("test power cycle done");
        wrap_up();
    end
endmodule : tb_fault_auto_restart_control
